// File: bench/acc_analog_model.sv
// Behavioural model of the analog core and the shared pin pads
`timescale 1ns/1ns
`default_nettype none
module acc_analog_model (
    input wire logic clock, // Bus clock
    input wire logic [4:0] core_channel, // Channel chosen by the control
    input wire logic core_enable, // Core powered
    input wire logic [9:0] analog_level, // Level on the selected input, as a code
    input wire logic [7:0] pin_out, // Pad output levels
    input wire logic [7:0] pin_oe, // Pad output enables
    input wire logic [7:0] ext_level, // Levels the board puts on undriven pads
    output logic [9:0] core_result, // Converted code
    output logic [7:0] pin_in // Levels seen at the pads
);
    logic [9:0] junk_q = 10'h155;
    // A powered-down core gives a pattern that moves every cycle, never a steady value
    always_ff @(posedge clock) begin
        junk_q <= junk_q + 10'h2a5;
    end
    // Powered pin channels 0 to 7 pass the level straight through; any other channel gives the moving pattern
    assign core_result = (core_enable && core_channel <= 5'h07) ? analog_level : junk_q;
    // A driven pad shows its own output, an undriven one the board level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// File: bench/acc_conv_ctrl_tb.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ns
`default_nettype none
module acc_conv_ctrl_tb;
    import acc_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic conv_clk_tick = 1'b0;
    logic stop_mode = 1'b0;
    logic wait_mode = 1'b0;
    logic [9:0] analog_level = 10'h2c5;
    logic [7:0] ext_level = 8'hff;
    wire logic [7:0] reg_rdata, pin_out, pin_oe, pin_in, analog_sel;
    wire logic [9:0] core_result;
    wire logic [4:0] core_channel;
    wire logic core_enable, conv_irq, wake_req;
    logic [2:0] div_q = 3'h0;
    logic [7:0] rv;
    logic [15:0] e;
    logic [9:0] lv [3] = '{10'h2c5, 10'h3ff, 10'h000};
    int ticks = 0;
    int cycles = 0;
    int t0;
    int mismatches = 0;
    int n_compared = 0;

    acc_conv_ctrl acc_conv_ctrl_i (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_clk_tick(conv_clk_tick), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .core_result(core_result), .core_channel(core_channel), .core_enable(core_enable),
        .core_sample(), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .analog_sel(analog_sel), .conv_clock_divider(), .conv_clock_source_sel(),
        .conv_irq(conv_irq), .wake_req(wake_req));
    acc_analog_model acc_analog_model_i (.clock(clock), .core_channel(core_channel),
        .core_enable(core_enable), .analog_level(analog_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_level(ext_level), .core_result(core_result), .pin_in(pin_in));

    always #10 clock = ~clock;
    // Converter clock every eight bus cycles keeps the run short, not the 1 MHz advised
    always @(posedge clock) begin
        div_q <= div_q + 3'h1;
        conv_clk_tick <= (div_q == 3'h7);
        if (conv_clk_tick) begin
            ticks <= ticks + 1;
        end
    end
    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rv = reg_rdata;
    endtask
    task automatic wait_ticks(input int n);
        int t;
        t = ticks;
        while (ticks < t + n) @(posedge clock);
    endtask
    task automatic wait_flag();
        int k;
        k = 0;
        rd(ADDR_STATUS_CTRL);
        while (rv[POS_COMPLETE] !== 1'b1 && k < 200) begin
            rd(ADDR_STATUS_CTRL);
            k++;
        end
    endtask
    function automatic logic [15:0] fmt(input int f, input logic [9:0] v);
        case (f)
            0: return {v[9:2], v[1:0], 6'h00};
            1: return {6'h00, v[9:8], v[7:0]};
            2: return {~v[9], v[8:2], v[1:0], 6'h00};
            default: return {8'h00, v[9:2]};
        endcase
    endfunction
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        // Reset state, powered off, unmapped place reads zero
        rd(ADDR_STATUS_CTRL);
        check(rv, 8'h1f);
        rd(ADDR_CLOCK_REG);
        check(rv, RST_CLOCK_REG);
        wr(3'h7, 8'hff);
        rd(3'h6);
        check(rv, 8'h00);
        // Pin override on channel 5
        wr(ADDR_PORT_DIR, 8'hff);
        wr(ADDR_PORT_DATA, 8'ha5);
        wr(ADDR_STATUS_CTRL, 8'h05);
        wr(ADDR_PORT_DIR, 8'hff);
        @(negedge clock);
        check(pin_oe, 8'hdf);
        check(analog_sel, 8'h20);
        check(pin_out, 8'ha5);
        rd(ADDR_PORT_DATA);
        check(rv, 8'h85);
        // Restart in mid conversion, then time it
        wait_ticks(5);
        wr(ADDR_STATUS_CTRL, 8'h05);
        t0 = ticks;
        while (ticks < t0 + 15) @(posedge clock);
        rd(ADDR_STATUS_CTRL);
        check(rv, 8'h05);
        while (ticks < t0 + 18) @(posedge clock);
        rd(ADDR_STATUS_CTRL);
        check(rv, 8'h85);
        rd(ADDR_RESULT_HIGH);
        rd(ADDR_STATUS_CTRL);
        check(rv, 8'h05);
        rd(ADDR_RESULT_LOW);
        wait_ticks(20);
        rd(ADDR_STATUS_CTRL);
        check(rv, 8'h05);
        // Every format at 2c5, full and zero scale
        for (int i = 0; i < 3; i++) begin
            analog_level <= lv[i];
            for (int f = 0; f < 4; f++) begin
                wr(ADDR_CLOCK_REG, 8'(f * 4));
                wr(ADDR_STATUS_CTRL, 8'h05);
                wait_flag();
                e = fmt(f, lv[i]);
                rd(ADDR_RESULT_HIGH);
                check(rv, e[15:8]);
                rd(ADDR_RESULT_LOW);
                check(rv, e[7:0]);
            end
        end
        // Continuous, left format: high read holds results until low read
        analog_level <= 10'h2c5;
        wr(ADDR_CLOCK_REG, 8'h00);
        wr(ADDR_STATUS_CTRL, 8'h25);
        wait_flag();
        rd(ADDR_RESULT_HIGH);
        check(rv, 8'hb1);
        analog_level <= 10'h13a;
        wait_ticks(40);
        rd(ADDR_RESULT_LOW);
        check(rv, 8'h40);
        wait_flag();
        rd(ADDR_RESULT_HIGH);
        check(rv, 8'h4e);
        rd(ADDR_RESULT_LOW);
        check(rv, 8'h80);
        // Truncation: unread results are overwritten
        wr(ADDR_CLOCK_REG, 8'h0c);
        analog_level <= 10'h0ff;
        wait_ticks(40);
        rd(ADDR_RESULT_LOW);
        check(rv, 8'h3f);
        // Stop halts conversions, they resume on exit
        @(posedge clock);
        stop_mode <= 1'b1;
        rd(ADDR_RESULT_LOW);
        check({7'h00, core_enable}, 8'h00);
        wait_ticks(40);
        rd(ADDR_STATUS_CTRL);
        check(rv, 8'h25);
        @(posedge clock);
        stop_mode <= 1'b0;
        analog_level <= 10'h200;
        wait_flag();
        rd(ADDR_RESULT_LOW);
        check(rv, 8'h80);
        // Interrupt instead of flag, wake in wait, clears on read or write
        wr(ADDR_STATUS_CTRL, 8'h45);
        for (int k = 0; k < 400 && conv_irq !== 1'b1; k++) @(posedge clock);
        rd(ADDR_STATUS_CTRL);
        check(rv, 8'h45);
        check({7'h00, conv_irq}, 8'h01);
        @(posedge clock);
        wait_mode <= 1'b1;
        @(negedge clock);
        check({7'h00, wake_req}, 8'h01);
        rd(ADDR_RESULT_LOW);
        @(negedge clock);
        check({7'h00, conv_irq}, 8'h00);
        wr(ADDR_STATUS_CTRL, 8'h45);
        for (int k = 0; k < 400 && conv_irq !== 1'b1; k++) @(posedge clock);
        wr(ADDR_STATUS_CTRL, 8'h05);
        @(negedge clock);
        check({7'h00, conv_irq}, 8'h00);
        // Power off hands every pin back to the port
        wr(ADDR_STATUS_CTRL, 8'h1f);
        @(negedge clock);
        check({7'h00, core_enable}, 8'h00);
        check(pin_oe, 8'hff);
        finish_test();
    end
endmodule
`default_nettype wire

// File: rtl/acc_conv_ctrl.sv
// Converter conversion control, result formatting and shared pin override
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module acc_conv_ctrl
    import acc_pkg::*;
(
    input wire logic clock, // 50 MHz bus clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [2:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, one cycle after strobe
    input wire logic conv_clk_tick, // One-cycle pulse per converter clock
    input wire logic stop_mode, // High while the part is in stop mode
    input wire logic wait_mode, // High while the part is in wait mode
    input wire logic [9:0] core_result, // Analog core ten-bit output
    output logic [4:0] core_channel, // Channel routed to the analog core
    output logic core_enable, // Analog core powered
    output logic core_sample, // Sampling window of the core
    input wire logic [7:0] pin_in, // Shared pin input levels
    output logic [7:0] pin_out, // Shared pin output levels
    output logic [7:0] pin_oe, // Shared pin output enables
    output logic [7:0] analog_sel, // Pin switch to the core, one hot, zero when no pin chosen
    output logic [2:0] conv_clock_divider, // Converter clock divider
    output logic conv_clock_source_sel, // Converter clock source
    output logic conv_irq, // Interrupt request, level
    output logic wake_req // Wake request in wait mode
);

    logic [4:0] channel_select_field_q;
    logic conv_irq_enable_q;
    logic continuous_conv_bit_q;
    logic conv_complete_flag_q;
    logic conv_irq_q;
    logic [7:0] conv_clock_reg_q;
    logic [7:0] port_data_q;
    logic [7:0] port_dir_q;
    logic [7:0] result_high_reg_q;
    logic [7:0] result_low_reg_q;
    logic [7:0] low_frozen_q;
    logic interlock_q;
    acc_state_t state_q;
    logic [4:0] cyc_q;
    logic [4:0] target_q;
    logic settle_q;
    logic [7:0] rdata_q;
    acc_fmt_t fmt;
    logic wr_ctrl, rd_high, rd_low, powered, conv_done;

    // Decode a channel code into a one-hot pin mask, zero when no pin chosen
    function automatic logic [7:0] pin_mask(input logic [4:0] ch);
        logic [7:0] m;
        m = 8'h00;
        if (ch <= CH_LAST_PIN) begin
            m[ch[2:0]] = 1'b1;
        end
        return m;
    endfunction

    assign fmt = acc_fmt_t'(conv_clock_reg_q[POS_FMT_HI:POS_FMT_LO]);
    assign wr_ctrl = reg_wr && (reg_addr == ADDR_STATUS_CTRL);
    assign rd_high = reg_rd && (reg_addr == ADDR_RESULT_HIGH);
    assign rd_low = reg_rd && (reg_addr == ADDR_RESULT_LOW);
    assign powered = (channel_select_field_q != CH_POWER_OFF) && !stop_mode;
    assign conv_done = (state_q == ST_CONVERT) && conv_clk_tick && (cyc_q == target_q);

    // Status/control register; a write that does not select power-off also starts a conversion below, outside stop mode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            channel_select_field_q <= RST_CHANNEL;
            conv_irq_enable_q <= 1'b0;
            continuous_conv_bit_q <= 1'b0;
        end else if (wr_ctrl) begin
            channel_select_field_q <= reg_wdata[4:0];
            conv_irq_enable_q <= reg_wdata[POS_IRQ_EN];
            continuous_conv_bit_q <= reg_wdata[POS_CONTINUOUS];
        end
    end

    // Clock register, port data and port direction registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            conv_clock_reg_q <= RST_CLOCK_REG;
            port_data_q <= 8'h00;
            port_dir_q <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CLOCK_REG) begin
                conv_clock_reg_q <= {reg_wdata[7:2], 2'b00};
            end else if (reg_addr == ADDR_PORT_DATA) begin
                // Selected bit keeps its old value so the override leaves no trace
                port_data_q <= (reg_wdata & ~analog_sel) | (port_data_q & analog_sel);
            end else if (reg_addr == ADDR_PORT_DIR) begin
                port_dir_q <= (reg_wdata & ~analog_sel) | (port_dir_q & analog_sel);
            end
        end
    end

    // Conversion sequencer: counts converter clocks and captures the core
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cyc_q <= 5'h00;
            target_q <= CONV_CYCLES;
            settle_q <= 1'b1;
        end else if (wr_ctrl && reg_wdata[4:0] != CH_POWER_OFF && !stop_mode) begin
            // Decoded from the written channel, so a write that powers the core up
            // from the off state still starts at once instead of being lost
            state_q <= ST_CONVERT;
            cyc_q <= 5'h01;
            target_q <= settle_q ? CONV_CYCLES_SETTLE : CONV_CYCLES;
            settle_q <= 1'b0;
        end else if (!powered || wr_ctrl) begin
            // Stop or power-off aborts; the next start pays a settling cycle
            state_q <= ST_IDLE;
            cyc_q <= 5'h00;
            settle_q <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (continuous_conv_bit_q) begin
                        state_q <= ST_CONVERT;
                        cyc_q <= 5'h01;
                        target_q <= settle_q ? CONV_CYCLES_SETTLE : CONV_CYCLES;
                        settle_q <= 1'b0;
                    end
                end
                ST_CONVERT: begin
                    if (conv_clk_tick) begin
                        if (cyc_q == target_q) begin
                            state_q <= ST_STORE;
                        end else begin
                            cyc_q <= cyc_q + 5'h01;
                        end
                    end
                end
                ST_STORE: begin
                    // Continuous restarts, single stops after one result
                    if (continuous_conv_bit_q) begin
                        state_q <= ST_CONVERT;
                        cyc_q <= 5'h01;
                        target_q <= CONV_CYCLES;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Result registers; interlock blocks stores after a high read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_high_reg_q <= 8'h00;
            result_low_reg_q <= 8'h00;
        end else if (conv_done && (!interlock_q || fmt == FMT_TRUNC8)) begin
            case (fmt)
                FMT_LEFT: begin
                    result_high_reg_q <= core_result[9:2];
                    result_low_reg_q <= {core_result[1:0], 6'h00};
                end
                FMT_RIGHT: begin
                    result_high_reg_q <= {6'h00, core_result[9:8]};
                    result_low_reg_q <= core_result[7:0];
                end
                FMT_SIGNED: begin
                    result_high_reg_q <= {~core_result[9], core_result[8:2]};
                    result_low_reg_q <= {core_result[1:0], 6'h00};
                end
                default: begin
                    result_high_reg_q <= 8'h00;
                    result_low_reg_q <= core_result[9:2];
                end
            endcase
        end
    end

    // High read latches low contents until low is read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            interlock_q <= 1'b0;
            low_frozen_q <= 8'h00;
        end else if (rd_high && fmt != FMT_TRUNC8) begin
            interlock_q <= 1'b1;
            low_frozen_q <= result_low_reg_q;
        end else if (rd_low || fmt == FMT_TRUNC8) begin
            interlock_q <= 1'b0;
        end
    end

    // Complete flag and interrupt; set wins over a same-cycle clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            conv_complete_flag_q <= 1'b0;
            conv_irq_q <= 1'b0;
        end else begin
            if (conv_done && !conv_irq_enable_q) begin
                conv_complete_flag_q <= 1'b1;
            end else if (rd_high || rd_low || conv_irq_enable_q) begin
                conv_complete_flag_q <= 1'b0;
            end
            if (conv_done && conv_irq_enable_q) begin
                conv_irq_q <= 1'b1;
            end else if (rd_high || rd_low || wr_ctrl) begin
                conv_irq_q <= 1'b0;
            end
        end
    end

    // Read data register, answer in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_STATUS_CTRL) begin
                rdata_q <= {conv_complete_flag_q, conv_irq_enable_q,
                            continuous_conv_bit_q, channel_select_field_q};
            end else if (reg_addr == ADDR_RESULT_HIGH) begin
                rdata_q <= result_high_reg_q;
            end else if (reg_addr == ADDR_RESULT_LOW) begin
                rdata_q <= interlock_q ? low_frozen_q : result_low_reg_q;
            end else if (reg_addr == ADDR_CLOCK_REG) begin
                rdata_q <= conv_clock_reg_q;
            end else if (reg_addr == ADDR_PORT_DATA) begin
                rdata_q <= ((port_dir_q & port_data_q) | (~port_dir_q & pin_in))
                           & ~analog_sel;
            end else if (reg_addr == ADDR_PORT_DIR) begin
                rdata_q <= port_dir_q;
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Pin override: selected pin is an input, others follow the port
    assign analog_sel = pin_mask(channel_select_field_q);
    assign pin_out = port_data_q;
    assign pin_oe = port_dir_q & ~analog_sel;
    assign core_channel = channel_select_field_q;
    assign core_enable = powered;
    assign core_sample = (state_q == ST_CONVERT);
    assign conv_clock_divider = conv_clock_reg_q[7:POS_DIV_LSB];
    assign conv_clock_source_sel = conv_clock_reg_q[POS_SRC_SEL];
    assign conv_irq = conv_irq_q;
    assign wake_req = conv_irq_q && wait_mode;
    assign reg_rdata = rdata_q;

    // Checks
    chk_sel_not_driven: assert property (@(posedge clock) disable iff (!rst_b)
        (pin_oe & analog_sel) == 8'h00) else $error("selected pin driven");
    chk_other_pins_port: assert property (@(posedge clock) disable iff (!rst_b)
        (pin_oe | analog_sel) == (port_dir_q | analog_sel)) else $error("port lost pin");
    chk_port_write_kept: assert property (@(posedge clock) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_PORT_DATA && !wr_ctrl |=> ((port_data_q & analog_sel)
        == ($past(port_data_q) & analog_sel))) else $error("selected bit written");
    chk_port_read_zero: assert property (@(posedge clock) disable iff (!rst_b)
        reg_rd && reg_addr == ADDR_PORT_DATA |=> (reg_rdata & $past(analog_sel)) == 8'h00)
        else $error("selected pin read nonzero");
    chk_write_starts: assert property (@(posedge clock) disable iff (!rst_b)
        wr_ctrl && reg_wdata[4:0] != CH_POWER_OFF && !stop_mode
        |=> state_q == ST_CONVERT && cyc_q == 5'h01)
        else $error("write did not start");
    chk_conv_bounded: assert property (@(posedge clock) disable iff (!rst_b)
        cyc_q <= CONV_CYCLES_SETTLE) else $error("conversion too long");
    chk_flag_set: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done && !conv_irq_enable_q |=> conv_complete_flag_q)
        else $error("flag not set");
    chk_flag_zero_irq: assert property (@(posedge clock) disable iff (!rst_b)
        conv_irq_enable_q |=> !conv_complete_flag_q) else $error("flag with irq");
    chk_irq_clears: assert property (@(posedge clock) disable iff (!rst_b)
        wr_ctrl && !conv_done |=> !conv_irq) else $error("irq not cleared");
    chk_single_stops: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == ST_STORE && !continuous_conv_bit_q && !wr_ctrl && powered
        |=> state_q == ST_IDLE) else $error("single did not stop");
    chk_interlock_hold: assert property (@(posedge clock) disable iff (!rst_b)
        interlock_q && fmt != FMT_TRUNC8 && !rd_low |=> $stable(low_frozen_q))
        else $error("frozen low changed");
    chk_stop_abort: assert property (@(posedge clock) disable iff (!rst_b)
        stop_mode |=> state_q == ST_IDLE) else $error("stop did not abort");

    // Result layout checks by format, all but truncation skipped while the interlock holds, then the interlock block check
    chk_trunc_high_zero: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done && fmt == FMT_TRUNC8 |=> result_high_reg_q == 8'h00)
        else $error("truncation high not zero");
    chk_right_high_top: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done && fmt == FMT_RIGHT && !interlock_q |=> result_high_reg_q[7:2] == 6'h00)
        else $error("right high upper bits set");
    chk_left_low_bits: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done && (fmt == FMT_LEFT || fmt == FMT_SIGNED) && !interlock_q
        |=> result_low_reg_q[5:0] == 6'h00) else $error("left low lower bits set");
    chk_signed_top: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done && fmt == FMT_SIGNED && !interlock_q
        |=> result_high_reg_q[7] == !$past(core_result[9])) else $error("sign not inverted");
    chk_interlock_blocks: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done && interlock_q && fmt != FMT_TRUNC8 |=> $stable(result_high_reg_q))
        else $error("result stored while locked");

    // Sequencing checks
    chk_continuous_restart: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == ST_STORE && continuous_conv_bit_q && powered && !wr_ctrl
        |=> state_q == ST_CONVERT) else $error("continuous did not restart");
    chk_done_window: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done |-> cyc_q >= CONV_CYCLES) else $error("conversion ended early");
    chk_plain_target: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == ST_STORE && continuous_conv_bit_q && powered && !wr_ctrl
        |=> target_q == CONV_CYCLES) else $error("restart target wrong");
    chk_store_once: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == ST_STORE |=> state_q != ST_STORE) else $error("store repeated");

    // Flag, interrupt, power and pin select checks
    chk_irq_set: assert property (@(posedge clock) disable iff (!rst_b)
        conv_done && conv_irq_enable_q |=> conv_irq) else $error("irq not raised");
    chk_flag_clear_read: assert property (@(posedge clock) disable iff (!rst_b)
        (rd_high || rd_low) && !conv_done |=> !conv_complete_flag_q)
        else $error("flag not cleared by read");
    chk_wake_follows: assert property (@(posedge clock) disable iff (!rst_b)
        wait_mode && conv_irq |-> wake_req) else $error("no wake in wait");
    chk_power_off: assert property (@(posedge clock) disable iff (!rst_b)
        core_channel == CH_POWER_OFF |-> !core_enable) else $error("core powered when off");
    chk_sel_one_hot: assert property (@(posedge clock) disable iff (!rst_b)
        core_channel <= CH_LAST_PIN |-> $onehot(analog_sel)) else $error("select not one hot");
    // Stop exit with continuous on should resume on its own
    cov_stop_resume: cover property (@(posedge clock) disable iff (!rst_b)
        $fell(stop_mode) && continuous_conv_bit_q);
    cov_single: cover property (@(posedge clock) disable iff (!rst_b)
        conv_done && !continuous_conv_bit_q);
    cov_continuous: cover property (@(posedge clock) disable iff (!rst_b)
        conv_done && continuous_conv_bit_q);
    cov_interlock_block: cover property (@(posedge clock) disable iff (!rst_b)
        conv_done && interlock_q);
    cov_irq: cover property (@(posedge clock) disable iff (!rst_b) $rose(conv_irq));

endmodule
`default_nettype wire

// File: rtl/acc_pkg.sv
// Constants for the converter conversion control block
package acc_pkg;
    // Register addresses on the plain register port
    localparam logic [2:0] ADDR_STATUS_CTRL = 3'h0;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h2;
    localparam logic [2:0] ADDR_CLOCK_REG = 3'h3;
    localparam logic [2:0] ADDR_PORT_DATA = 3'h4;
    localparam logic [2:0] ADDR_PORT_DIR = 3'h5;
    // Status/control field positions
    localparam int POS_COMPLETE = 7;
    localparam int POS_IRQ_EN = 6;
    localparam int POS_CONTINUOUS = 5;
    // Clock register field positions
    localparam int POS_DIV_LSB = 5;
    localparam int POS_SRC_SEL = 4;
    localparam int POS_FMT_HI = 3;
    localparam int POS_FMT_LO = 2;
    // Reset values
    localparam logic [4:0] RST_CHANNEL = 5'h1f;
    localparam logic [7:0] RST_CLOCK_REG = 8'h04;
    // Channel codes
    localparam logic [4:0] CH_POWER_OFF = 5'h1f;
    localparam logic [4:0] CH_LAST_PIN = 5'h07;
    // Conversion timing in converter clock cycles, then the full-scale code
    localparam logic [4:0] CONV_CYCLES = 5'h10;
    localparam logic [4:0] CONV_CYCLES_SETTLE = 5'h11;
    localparam logic [10:0] FULL_SCALE = 11'h3ff;
    // Result formats
    typedef enum logic [1:0] {
        FMT_LEFT = 2'b00,
        FMT_RIGHT = 2'b01,
        FMT_SIGNED = 2'b10,
        FMT_TRUNC8 = 2'b11
    } acc_fmt_t;
    // Conversion control states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_STORE = 2'b10
    } acc_state_t;
endpackage
